// [rtl/bfc_top.sv]
// Backlight driver fault supervision, current and frequency selection
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "bfc_params.svh"

module bfc_top #(
	parameter logic NONSER_2X = 1'b0
) (
	// Clock and reset
	input  wire logic                          CLOCK,
	input  wire logic                          SYS_RST,
	// Device pins
	input  wire logic                          EN_PIN,
	input  wire logic                          SERIAL_SEL,
	input  wire logic                          FSET_HIGH,
	input  wire logic                          FSET_LOW,
	input  wire logic                          PWM_IN,
	// Comparators from the power stage
	input  wire bfc_pkg::bfc_cmp_t             CMP,
	// Register port
	input  wire logic [7:0]                    REG_ADDR,
	input  wire logic [31:0]                   REG_WDATA,
	input  wire logic                          REG_WR,
	input  wire logic                          REG_RD,
	output logic [31:0]                        REG_RDATA,
	// Power stage controls
	output bfc_pkg::bfc_drive_t                DRIVE,
	output logic [`BFC_LEVEL_W-1:0]            SINK_LEVEL,
	output logic                               BOOST_TICK,
	output logic                               PUMP_TICK
);

	////////////////////////////////////////////////////////////////////////////////
	// State and helpers

	localparam bfc_pkg::bfc_regs_t REGS_DEFAULT = '{
		channel_enable_bits:  '0,
		full_scale:           `BFC_FS_DEFAULT,
		doubler_ratio_select: 1'b0,
		boost_frequency_code: `BFC_FSW_DEFAULT,
		pump_frequency_ratio: `BFC_CP_DEF_SERIAL
	};

	bfc_pkg::bfc_top_t       s_q;
	bfc_pkg::bfc_top_t       s_d;
	logic                    boost_tick;
	logic                    pump_tick;
	logic [`BFC_LEVEL_W-1:0] duty_level;
	logic                    run;
	logic [4:0]              fsw_code;
	logic [1:0]              cp_ratio;

	logic                    en_s;
	logic                    wr_cmd;
	logic                    rst_evt;
	logic                    wr_chan;
	logic                    rd_first;
	logic                    rd_second;
	logic [`BFC_NCH-1:0]     chan_on;
	logic                    any_on;
	logic [`BFC_NCH-1:0]     chan_fall;
	logic [`BFC_NCH-1:0]     short_set;
	logic [`BFC_NCH-1:0]     open_set;
	logic [`BFC_NCH-1:0]     second_clr;
	logic                    halt;
	bfc_pkg::bfc_cmp_t       c;

	////////////////////////////////////////////////////////////////////////////////
	// Sub-blocks

	bfc_freq_gen u_freq (
		.clk        (CLOCK),
		.rst        (SYS_RST),
		.run        (run),
		.code       (fsw_code),
		.cp_ratio   (cp_ratio),
		.boost_tick (boost_tick),
		.pump_tick  (pump_tick)
	);

	bfc_duty_meter u_duty (
		.clk   (CLOCK),
		.rst   (SYS_RST),
		.pwm   (s_q.pwm_sync[1]),
		.level (duty_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d = s_q;
		c = s_q.cmp_b;
		en_s = s_q.en_sync[1];

		// Pin synchronisers
		s_d.en_sync  = {s_q.en_sync[0], EN_PIN};
		s_d.ser_sync = {s_q.ser_sync[0], SERIAL_SEL};
		s_d.fhi_sync = {s_q.fhi_sync[0], FSET_HIGH};
		s_d.flo_sync = {s_q.flo_sync[0], FSET_LOW};
		s_d.pwm_sync = {s_q.pwm_sync[0], PWM_IN};
		s_d.cmp_a = CMP;
		s_d.cmp_b = s_q.cmp_a;

		// Strap capture once, after the synchronisers have filled
		if (!s_q.started) begin
			if (s_q.start_cnt == `BFC_START_WAIT) begin
				s_d.started = 1'b1;
				s_d.serial_mode = s_q.ser_sync[1];
				if (s_q.fhi_sync[1]) begin
					s_d.strap_code = `BFC_FSW_STRAP_HI;
				end else if (s_q.flo_sync[1]) begin
					s_d.strap_code = `BFC_FSW_STRAP_LO;
				end else begin
					s_d.strap_code = `BFC_FSW_STRAP_OPEN;
				end
			end else begin
				s_d.start_cnt = s_q.start_cnt + 2'h1;
			end
		end

		// Bus decode
		wr_cmd = REG_WR && (REG_ADDR == `BFC_ADDR_COMMAND);
		wr_chan = REG_WR && (REG_ADDR == `BFC_ADDR_CHAN_EN);
		rd_first = REG_RD && (REG_ADDR == `BFC_ADDR_FAULT1);
		rd_second = REG_RD && (REG_ADDR == `BFC_ADDR_FAULT2);
		rst_evt = !en_s || (wr_cmd && REG_WDATA[`BFC_CMD_RESET_BIT]);

		// Channel view
		if (s_q.serial_mode) begin
			chan_on = s_q.regs.channel_enable_bits;
		end else begin
			chan_on = {`BFC_NCH{1'b1}};
		end
		chan_on = chan_on & {`BFC_NCH{en_s && s_q.started}};
		any_on = |chan_on;
		chan_fall = s_q.chan_prev & ~chan_on;
		s_d.chan_prev = chan_on;

		// Latched shutdowns
		if (c.flycap_ov || c.sec_ilim) begin
			s_d.latched_off = 1'b1;
		end
		if (c.out_short) begin
			s_d.disc_open = 1'b1;
		end
		halt = s_q.latched_off || c.flycap_ov || c.sec_ilim;

		// Per-sink short hold and open-string voltage-control block
		short_set = c.sink_short & chan_on;
		open_set = {`BFC_NCH{c.out_ov}} & c.sink_low & chan_on & ~s_q.open_block;
		if (!any_on) begin
			s_d.short_off = '0;
		end else begin
			s_d.short_off = s_q.short_off | short_set;
		end
		s_d.open_block = (s_q.open_block & ~chan_fall) | open_set;

		// Pump doubler select taken on enable, held while any channel runs
		if (s_q.serial_mode) begin
			if (any_on && ~|s_q.chan_prev) begin
				s_d.doubler_lock = s_q.regs.doubler_ratio_select;
			end
		end else begin
			s_d.doubler_lock = NONSER_2X;
		end

		// Soft-start count in boost cycles
		if (!any_on || halt) begin
			s_d.ss_cnt = 8'h00;
		end else if (boost_tick && s_q.ss_cnt != `BFC_SS_CYCLES) begin
			s_d.ss_cnt = s_q.ss_cnt + 8'h01;
		end

		// Fault status: read clears the first word, the second only for sinks switched off since its last read; a new event in the same cycle wins
		if (rd_first) begin
			s_d.fault_first = '0;
		end
		s_d.fault_first.flycap_overvoltage_flag =
			s_d.fault_first.flycap_overvoltage_flag | c.flycap_ov;
		s_d.fault_first.secondary_current_limit_flag =
			s_d.fault_first.secondary_current_limit_flag | c.sec_ilim;
		s_d.fault_first.disconnect_overcurrent_flag =
			s_d.fault_first.disconnect_overcurrent_flag | c.out_short;

		s_d.clear_arm = s_q.clear_arm | chan_fall;
		second_clr = rd_second ? s_q.clear_arm : '0;
		if (rd_second) begin
			s_d.clear_arm = chan_fall;
		end
		s_d.fault_second.string_short_flag =
			(s_q.fault_second.string_short_flag & ~second_clr) | short_set;
		s_d.fault_second.string_open_flag =
			(s_q.fault_second.string_open_flag & ~second_clr) | open_set;

		// Register writes
		if (REG_WR) begin
			case (REG_ADDR)
				`BFC_ADDR_CHAN_EN: begin
					s_d.regs.channel_enable_bits = REG_WDATA[`BFC_NCH-1:0];
				end
				`BFC_ADDR_SINK_CFG: begin
					s_d.regs.full_scale = REG_WDATA[`BFC_CFG_FS_LSB +: 2];
					s_d.regs.doubler_ratio_select = REG_WDATA[`BFC_CFG_DBL_BIT];
				end
				`BFC_ADDR_BOOST_CFG: begin
					s_d.regs.boost_frequency_code = REG_WDATA[`BFC_BST_FSW_LSB +: 5];
					s_d.regs.pump_frequency_ratio = REG_WDATA[`BFC_BST_CP_LSB +: 2];
				end
				default: begin
				end
			endcase
		end

		// Register reads, data in the following cycle
		if (REG_RD) begin
			case (REG_ADDR)
				`BFC_ADDR_CHAN_EN: begin
					s_d.rdata = {26'h0, s_q.regs.channel_enable_bits};
				end
				`BFC_ADDR_SINK_CFG: begin
					s_d.rdata = {29'h0, s_q.regs.doubler_ratio_select, s_q.regs.full_scale};
				end
				`BFC_ADDR_BOOST_CFG: begin
					s_d.rdata = {22'h0, s_q.regs.pump_frequency_ratio, 3'h0,
						s_q.regs.boost_frequency_code};
				end
				`BFC_ADDR_FAULT1: begin
					s_d.rdata = {29'h0, s_q.fault_first};
				end
				`BFC_ADDR_FAULT2: begin
					s_d.rdata = {20'h0, s_q.fault_second};
				end
				`BFC_ADDR_STATE: begin
					s_d.rdata = {10'h000, s_q.serial_mode, s_q.doubler_lock, s_q.disc_open,
						s_q.latched_off, s_q.open_block, 6'h0, s_q.short_off};
				end
				default: begin
					s_d.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Reset event: registers and latches to their ready values
		if (rst_evt) begin
			s_d.regs = REGS_DEFAULT;
			s_d.fault_first = '0;
			s_d.fault_second = '0;
			s_d.clear_arm = '0;
			s_d.short_off = '0;
			s_d.open_block = '0;
			s_d.latched_off = 1'b0;
			s_d.disc_open = 1'b0;
			s_d.doubler_lock = 1'b0;
			s_d.ss_cnt = 8'h00;
		end

		// Drive toward the power stage
		s_d.drv.boost_en = any_on && !halt && !rst_evt;
		s_d.drv.sink_en = chan_on & ~s_d.short_off & {`BFC_NCH{!halt && !s_d.disc_open &&
			!c.out_short && !rst_evt}};
		s_d.drv.sink_vctrl = s_d.drv.sink_en & ~s_d.open_block;
		s_d.drv.disconnect_open = s_d.disc_open || c.out_short;
		s_d.drv.ilim_soft = s_d.ss_cnt != `BFC_SS_CYCLES;
		if (!s_d.drv.boost_en || c.pri_ilim) begin
			s_d.drv.lowside_on = 1'b0;
		end else if (boost_tick) begin
			s_d.drv.lowside_on = 1'b1;
		end
		s_d.drv.pump_2x = s_d.doubler_lock;
		s_d.drv.fs_from_pin = !s_q.serial_mode;
		s_d.drv.full_scale = s_q.serial_mode ? s_q.regs.full_scale : `BFC_FS_DEFAULT;
		s_d.level = s_q.serial_mode ? `BFC_LEVEL_FULL : duty_level;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frequency selection

	always_comb begin
		run = s_q.drv.boost_en;
		if (!s_q.serial_mode) begin
			fsw_code = s_q.strap_code;
			cp_ratio = `BFC_CP_DEF_STRAP;
		end else begin
			cp_ratio = s_q.regs.pump_frequency_ratio;
			if (s_q.regs.boost_frequency_code < `BFC_FSW_MIN) begin
				fsw_code = `BFC_FSW_MIN;
			end else begin
				fsw_code = s_q.regs.boost_frequency_code;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			s_q <= '0;
			s_q.regs <= REGS_DEFAULT;
		end else begin
			s_q <= s_d;
		end
	end

	assign REG_RDATA  = s_q.rdata;
	assign DRIVE      = s_q.drv;
	assign SINK_LEVEL = s_q.level;
	assign BOOST_TICK = boost_tick;
	assign PUMP_TICK  = pump_tick;

endmodule : bfc_top

`default_nettype wire

// [pkg/bfc_params.svh]
// Constants of the backlight fault and frequency control block
`ifndef BFC_PARAMS_SVH
`define BFC_PARAMS_SVH

// Register offsets (byte addresses)
`define BFC_ADDR_COMMAND    8'h00
`define BFC_ADDR_CHAN_EN    8'h04
`define BFC_ADDR_SINK_CFG   8'h08
`define BFC_ADDR_BOOST_CFG  8'h0C
`define BFC_ADDR_FAULT1     8'h10
`define BFC_ADDR_FAULT2     8'h14
`define BFC_ADDR_STATE      8'h18

// Field positions
`define BFC_CMD_RESET_BIT   0
`define BFC_CFG_FS_LSB      0
`define BFC_CFG_DBL_BIT     2
`define BFC_BST_FSW_LSB     0
`define BFC_BST_CP_LSB      8

// Widths
`define BFC_NCH             6
`define BFC_LEVEL_W         12

// Reset values and codes
`define BFC_FS_DEFAULT      2'h0
`define BFC_FSW_DEFAULT     5'h09
`define BFC_FSW_MIN         5'h02
`define BFC_CP_EIGHTH       2'h0
`define BFC_CP_QUARTER      2'h1
`define BFC_CP_HALF         2'h2
`define BFC_CP_DEF_SERIAL   2'h1
`define BFC_CP_DEF_STRAP    2'h0
`define BFC_FSW_STRAP_HI    5'h03
`define BFC_FSW_STRAP_OPEN  5'h09
`define BFC_FSW_STRAP_LO    5'h13
`define BFC_LEVEL_FULL      12'hFFF

// Timing: core clock and reference rate in kHz
`define BFC_CLK_KHZ         17'h186A0
`define BFC_REF_KHZ         17'h02800
`define BFC_SS_CYCLES       8'h40
`define BFC_START_WAIT      2'h3

`endif

// [pkg/bfc_pkg.sv]
// Types of the backlight fault and frequency control block
`include "bfc_params.svh"

package bfc_pkg;

	// Analog comparator outputs
	typedef struct packed {
		logic                    flycap_ov;
		logic                    sec_ilim;
		logic                    out_short;
		logic                    out_ov;
		logic                    pri_ilim;
		logic [`BFC_NCH-1:0]     sink_short;
		logic [`BFC_NCH-1:0]     sink_low;
	} bfc_cmp_t;

	// First fault status register, bits 2..0
	typedef struct packed {
		logic disconnect_overcurrent_flag;
		logic secondary_current_limit_flag;
		logic flycap_overvoltage_flag;
	} bfc_fault_first_t;

	// Second fault status register: open in [11:6], short in [5:0]
	typedef struct packed {
		logic [`BFC_NCH-1:0] string_open_flag;
		logic [`BFC_NCH-1:0] string_short_flag;
	} bfc_fault_second_t;

	// Software settings
	typedef struct packed {
		logic [`BFC_NCH-1:0] channel_enable_bits;
		logic [1:0]          full_scale;
		logic                doubler_ratio_select;
		logic [4:0]          boost_frequency_code;
		logic [1:0]          pump_frequency_ratio;
	} bfc_regs_t;

	// Controls toward the power stage
	typedef struct packed {
		logic                boost_en;
		logic                lowside_on;
		logic                ilim_soft;
		logic                disconnect_open;
		logic                pump_2x;
		logic                fs_from_pin;
		logic [1:0]          full_scale;
		logic [`BFC_NCH-1:0] sink_en;
		logic [`BFC_NCH-1:0] sink_vctrl;
	} bfc_drive_t;

	// Whole state of the top module
	typedef struct packed {
		logic [1:0]               en_sync;
		logic [1:0]               ser_sync;
		logic [1:0]               fhi_sync;
		logic [1:0]               flo_sync;
		logic [1:0]               pwm_sync;
		bfc_cmp_t                 cmp_a;
		bfc_cmp_t                 cmp_b;
		logic [1:0]               start_cnt;
		logic                     started;
		logic                     serial_mode;
		logic [4:0]               strap_code;
		bfc_regs_t                regs;
		logic [`BFC_NCH-1:0]      chan_prev;
		bfc_fault_first_t         fault_first;
		bfc_fault_second_t        fault_second;
		logic [`BFC_NCH-1:0]      clear_arm;
		logic [`BFC_NCH-1:0]      short_off;
		logic [`BFC_NCH-1:0]      open_block;
		logic                     latched_off;
		logic                     disc_open;
		logic                     doubler_lock;
		logic [7:0]               ss_cnt;
		logic [31:0]              rdata;
		bfc_drive_t               drv;
		logic [`BFC_LEVEL_W-1:0]  level;
	} bfc_top_t;

	// Frequency generator state
	typedef struct packed {
		logic [16:0] acc;
		logic [4:0]  div;
		logic [2:0]  pdiv;
		logic        btick;
		logic        ptick;
	} bfc_freq_t;

	// Duty meter state
	typedef struct packed {
		logic [`BFC_LEVEL_W-1:0] win;
		logic [`BFC_LEVEL_W:0]   high;
		logic [`BFC_LEVEL_W-1:0] level;
	} bfc_duty_t;

endpackage : bfc_pkg

// [rtl/bfc_freq_gen.sv]
// Boost and charge-pump switching tick generator
`timescale 1ns/1ps
`default_nettype none
`include "bfc_params.svh"

module bfc_freq_gen (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Settings
	input  wire logic       run,
	input  wire logic [4:0] code,
	input  wire logic [1:0] cp_ratio,
	// Ticks
	output logic            boost_tick,
	output logic            pump_tick
);

	bfc_pkg::bfc_freq_t s_q;
	bfc_pkg::bfc_freq_t s_d;
	logic [16:0]        sum;
	logic [2:0]         plim;

	always_comb begin
		s_d = s_q;
		s_d.btick = 1'b0;
		s_d.ptick = 1'b0;
		sum = s_q.acc + `BFC_REF_KHZ;
		case (cp_ratio)
			`BFC_CP_EIGHTH:  plim = 3'h7;
			`BFC_CP_QUARTER: plim = 3'h3;
			default:         plim = 3'h1;
		endcase
		if (!run) begin
			s_d.div = 5'h00;
			s_d.pdiv = 3'h0;
		end else if (sum >= `BFC_CLK_KHZ) begin
			// Reference tick; boost period is code plus one reference ticks
			s_d.acc = sum - `BFC_CLK_KHZ;
			if (s_q.div >= code) begin
				s_d.div = 5'h00;
				s_d.btick = 1'b1;
				if (s_q.pdiv >= plim) begin
					s_d.pdiv = 3'h0;
					s_d.ptick = 1'b1;
				end else begin
					s_d.pdiv = s_q.pdiv + 3'h1;
				end
			end else begin
				s_d.div = s_q.div + 5'h01;
			end
		end else begin
			s_d.acc = sum;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign boost_tick = s_q.btick;
	assign pump_tick  = s_q.ptick;

endmodule : bfc_freq_gen

`default_nettype wire

// [rtl/bfc_duty_meter.sv]
// Duty-cycle meter for the dimming input
`timescale 1ns/1ps
`default_nettype none
`include "bfc_params.svh"

module bfc_duty_meter (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Synchronised input
	input  wire logic                    pwm,
	// Measured duty
	output logic [`BFC_LEVEL_W-1:0]      level
);

	bfc_pkg::bfc_duty_t s_q;
	bfc_pkg::bfc_duty_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.win = s_q.win + 1'b1;
		s_d.high = s_q.high + {{`BFC_LEVEL_W{1'b0}}, pwm};
		if (s_q.win == `BFC_LEVEL_FULL) begin
			// End of window: publish high count, saturated
			if (s_d.high[`BFC_LEVEL_W]) begin
				s_d.level = `BFC_LEVEL_FULL;
			end else begin
				s_d.level = s_d.high[`BFC_LEVEL_W-1:0];
			end
			s_d.high = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.level;

endmodule : bfc_duty_meter

`default_nettype wire

// [verif/bfc_checker.sv]
// Port checks of the backlight control block
`timescale 1ns/1ps
`default_nettype none
`include "bfc_params.svh"

module bfc_checker (
	// Clock and reset
	input  wire logic                CLOCK,
	input  wire logic                SYS_RST,
	// Pins and comparators
	input  wire logic                EN_PIN,
	input  wire bfc_pkg::bfc_cmp_t   CMP,
	// Register port
	input  wire logic [7:0]          REG_ADDR,
	input  wire logic                REG_WR,
	input  wire logic                REG_RD,
	input  wire logic [31:0]         REG_RDATA,
	// Power stage
	input  wire bfc_pkg::bfc_drive_t DRIVE
);
	logic quiet;
	logic rd1;
	assign quiet = !CMP.flycap_ov && !CMP.sec_ilim && !CMP.out_short;
	assign rd1   = REG_RD && REG_ADDR == `BFC_ADDR_FAULT1;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	////////////////////////////////////////////////////////////////
	property p_flycap_off;
		(CMP.flycap_ov && EN_PIN)[*3] |=> !DRIVE.boost_en && DRIVE.sink_en == 6'h00;
	endproperty
	a_flycap_off: assert property (p_flycap_off)
		else $error("flycap trip left the stage on");
	property p_flycap_hold;
		(CMP.flycap_ov && EN_PIN)[*3] ##1 (EN_PIN && !REG_WR)[*8] |=> !DRIVE.boost_en;
	endproperty
	a_flycap_hold: assert property (p_flycap_hold)
		else $error("boost restarted without reset");
	property p_short_one;
		(DRIVE.sink_en[2] && CMP.sink_short[2] && EN_PIN && !REG_WR)[*3] |=> !DRIVE.sink_en[2];
	endproperty
	a_short_one: assert property (p_short_one)
		else $error("shorted sink still on");
	property p_sec_off;
		(CMP.sec_ilim && EN_PIN)[*3] |=> !DRIVE.boost_en && DRIVE.sink_en == 6'h00;
	endproperty
	a_sec_off: assert property (p_sec_off)
		else $error("overcurrent left the stage on");
	property p_out_short;
		(CMP.out_short && EN_PIN)[*3] |=> DRIVE.disconnect_open && DRIVE.sink_en == 6'h00;
	endproperty
	a_out_short: assert property (p_out_short)
		else $error("output short not disconnected");
	property p_read_clear;
		quiet[*2] ##1 (quiet && rd1) ##2 rd1 |=> REG_RDATA[2:0] == 3'h0;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("first fault word not cleared by read");
	property p_cmd_zero;
		REG_RD && (REG_ADDR == `BFC_ADDR_COMMAND || REG_ADDR == 8'h1C) |=> REG_RDATA == 32'h0;
	endproperty
	a_cmd_zero: assert property (p_cmd_zero)
		else $error("command or hole read not zero");
	property p_lowside;
		(CMP.pri_ilim && EN_PIN)[*3] |=> !DRIVE.lowside_on;
	endproperty
	a_lowside: assert property (p_lowside)
		else $error("low side on at current limit");
	property p_en_off;
		(!EN_PIN)[*3] |=> DRIVE.sink_en == 6'h00 && !DRIVE.boost_en && !DRIVE.disconnect_open;
	endproperty
	a_en_off: assert property (p_en_off)
		else $error("stage on with enable low");
	c_all_on: cover property (DRIVE.boost_en && DRIVE.sink_en == 6'h3F);
	c_short: cover property ($fell(DRIVE.sink_en[2]) && DRIVE.sink_en[0]);
	c_disc: cover property (DRIVE.disconnect_open);
endmodule : bfc_checker

bind bfc_top bfc_checker chk_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .EN_PIN(EN_PIN), .CMP(CMP),
	.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.DRIVE(DRIVE));
`default_nettype wire

// [verif/bfc_stage_model.sv]
// Behavioural comparators of the power stage
`timescale 1ns/1ps
`default_nettype none

module bfc_stage_model (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// Faults asked for and stage controls
	input  wire bfc_pkg::bfc_cmp_t   fault_req,
	input  wire bfc_pkg::bfc_drive_t drive,
	// Comparator outputs
	output bfc_pkg::bfc_cmp_t        cmp
);
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp <= '0;
		end else begin
			cmp            <= fault_req;
			// Pin comparators only see sinks that carry current
			cmp.sink_short <= fault_req.sink_short & drive.sink_en;
			cmp.sink_low   <= fault_req.sink_low & drive.sink_en;
			// Output rises while an open string still holds control
			cmp.out_ov     <= |(fault_req.sink_low & drive.sink_vctrl);
		end
	end
endmodule : bfc_stage_model
`default_nettype wire

// [verif/test_bfc_top.sv]
// Self-checking bench of the backlight control block
`timescale 1ns/1ps
`default_nettype none
`include "bfc_params.svh"

module test_bfc_top;
	logic                clock;
	logic                sys_rst;
	logic                en_pin;
	logic                serial_sel;
	logic                fset_high;
	logic                fset_low;
	logic                pwm_in;
	bfc_pkg::bfc_cmp_t   fault_req;
	bfc_pkg::bfc_cmp_t   cmp;
	bfc_pkg::bfc_cmp_t   v;
	logic [7:0]          reg_addr;
	logic [31:0]         reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [31:0]         reg_rdata;
	logic [31:0]         rdv;
	bfc_pkg::bfc_drive_t drive;
	logic [11:0]         sink_level;
	logic                boost_tick;
	logic                pump_tick;
	int                  n_mismatch;
	int                  total_checks;

	bfc_top dut_u (.CLOCK(clock), .SYS_RST(sys_rst), .EN_PIN(en_pin), .SERIAL_SEL(serial_sel),
		.FSET_HIGH(fset_high), .FSET_LOW(fset_low), .PWM_IN(pwm_in), .CMP(cmp), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.DRIVE(drive), .SINK_LEVEL(sink_level), .BOOST_TICK(boost_tick),
		.PUMP_TICK(pump_tick));
	bfc_stage_model stage_u (.clk(clock), .rst(sys_rst), .fault_req(fault_req),
		.drive(drive), .cmp(cmp));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : wt
	task automatic count_ticks(output int nb, output int np);
		nb = 0;
		np = 0;
		repeat (6200) begin
			@(posedge clock);
			#1;
			nb += int'(boost_tick);
			np += int'(pump_tick);
		end
	endtask : count_ticks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rdv = reg_rdata;
	endtask : rd
	task automatic pulse(input bfc_pkg::bfc_cmp_t f);
		@(posedge clock);
		fault_req <= f;
		wt(6);
		@(posedge clock);
		fault_req <= '0;
		wt(6);
	endtask : pulse
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		check(rdv, e);
	endtask : chk_rd
	////////////////////////////////////////////////////////////////
	task automatic t_defaults;
		chk_rd(`BFC_ADDR_SINK_CFG, 32'h0);
		chk_rd(`BFC_ADDR_BOOST_CFG, 32'h109);
		chk_rd(`BFC_ADDR_COMMAND, 32'h0);
		chk_rd(8'h1C, 32'h0);
		wr(`BFC_ADDR_CHAN_EN, 32'h3F);
		for (int i = 0; i < 4; i++) begin
			wr(`BFC_ADDR_SINK_CFG, 32'(i));
			wt(4);
			check({30'h0, drive.full_scale}, 32'(i));
		end
		wr(`BFC_ADDR_SINK_CFG, 32'h0);
		$display("defaults and current codes done");
	endtask : t_defaults
	task automatic t_strings;
		v = '0;
		v.sink_short = 6'h04;
		pulse(v);
		check({26'h0, drive.sink_en}, 32'h3B);
		chk_rd(`BFC_ADDR_FAULT2, 32'h4);
		chk_rd(`BFC_ADDR_FAULT2, 32'h4);
		wr(`BFC_ADDR_CHAN_EN, 32'h3B);
		chk_rd(`BFC_ADDR_FAULT2, 32'h4);
		chk_rd(`BFC_ADDR_FAULT2, 32'h0);
		wr(`BFC_ADDR_CHAN_EN, 32'h3F);
		wt(4);
		check({26'h0, drive.sink_en}, 32'h3B);
		wr(`BFC_ADDR_CHAN_EN, 32'h0);
		wr(`BFC_ADDR_CHAN_EN, 32'h3F);
		wt(4);
		check({26'h0, drive.sink_en}, 32'h3F);
		v = '0;
		v.sink_low = 6'h10;
		@(posedge clock);
		fault_req <= v;
		wt(10);
		check({26'h0, drive.sink_vctrl}, 32'h2F);
		chk_rd(`BFC_ADDR_FAULT2, 32'h400);
		@(posedge clock);
		fault_req <= '0;
		wt(10);
		check({26'h0, drive.sink_en}, 32'h3F);
		check({26'h0, drive.sink_vctrl}, 32'h2F);
		wr(`BFC_ADDR_CHAN_EN, 32'h2F);
		wr(`BFC_ADDR_CHAN_EN, 32'h3F);
		wt(4);
		check({26'h0, drive.sink_vctrl}, 32'h3F);
		$display("string faults done");
	endtask : t_strings
	task automatic t_latch;
		for (int k = 0; k < 3; k++) begin
			v = '0;
			v.flycap_ov = k == 0;
			v.sec_ilim  = k == 1;
			v.out_short = k == 2;
			pulse(v);
			wt(20);
			check({26'h0, drive.sink_en}, 32'h0);
			check({31'h0, drive.boost_en}, {31'h0, k == 2});
			check({31'h0, drive.disconnect_open}, {31'h0, k == 2});
			chk_rd(`BFC_ADDR_FAULT1, 32'(1 << k));
			chk_rd(`BFC_ADDR_FAULT1, 32'h0);
			if (k == 1) begin
				@(posedge clock);
				en_pin <= 1'b0;
				wt(4);
				@(posedge clock);
				en_pin <= 1'b1;
				wt(10);
			end else begin
				wr(`BFC_ADDR_COMMAND, 32'h1);
				wt(4);
			end
			chk_rd(`BFC_ADDR_CHAN_EN, 32'h0);
			wr(`BFC_ADDR_CHAN_EN, 32'h3F);
			wt(4);
			check({25'h0, drive.disconnect_open, drive.sink_en}, 32'h3F);
		end
		$display("latched faults done");
	endtask : t_latch
	task automatic t_doubler;
		wr(`BFC_ADDR_CHAN_EN, 32'h0);
		wr(`BFC_ADDR_SINK_CFG, 32'h4);
		wr(`BFC_ADDR_CHAN_EN, 32'h3F);
		wr(`BFC_ADDR_SINK_CFG, 32'h0);
		wt(4);
		check({31'h0, drive.pump_2x}, 32'h1);
		wr(`BFC_ADDR_CHAN_EN, 32'h0);
		wr(`BFC_ADDR_CHAN_EN, 32'h3F);
		wt(4);
		check({31'h0, drive.pump_2x}, 32'h0);
		$display("doubler lock done");
	endtask : t_doubler
	task automatic t_freq;
		int nb;
		int np;
		int ex;
		int s;
		logic [4:0] code;
		v = '0;
		v.pri_ilim = 1'b1;
		pulse(v);
		for (int r = 0; r < 3; r++) begin
			code = r == 0 ? 5'h02 : r == 1 ? 5'h00 : 5'h1F;
			ex = r == 2 ? 20 : 212;
			s = 3 - r;
			wr(`BFC_ADDR_BOOST_CFG, {22'h0, 2'(r), 3'h0, code});
			wt(100);
			count_ticks(nb, np);
			check({31'h0, nb >= ex - 1 && nb <= ex + 1}, 32'h1);
			check({31'h0, np >= (nb >> s) - 1 && np <= (nb >> s) + 1}, 32'h1);
		end
		$display("frequencies done");
	endtask : t_freq
	task automatic t_strap;
		int nb;
		int np;
		@(posedge clock);
		sys_rst    <= 1'b1;
		serial_sel <= 1'b0;
		fset_high  <= 1'b1;
		pwm_in     <= 1'b1;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		wt(20);
		check({31'h0, drive.ilim_soft}, 32'h1);
		@(posedge clock);
		fset_high <= 1'b0;
		fset_low  <= 1'b1;
		count_ticks(nb, np);
		check({31'h0, nb >= 158 && nb <= 160}, 32'h1);
		check({31'h0, np >= 18 && np <= 21}, 32'h1);
		wt(2200);
		check({31'h0, drive.ilim_soft}, 32'h0);
		check({31'h0, drive.fs_from_pin}, 32'h1);
		check({20'h0, sink_level}, 32'hFFF);
		$display("strap mode done");
	endtask : t_strap
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end
	initial begin
		sys_rst = 1'b1;
		en_pin = 1'b1;
		fault_req = '0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		serial_sel = 1'b1;
		fset_high = 1'b0;
		fset_low = 1'b0;
		pwm_in = 1'b0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		wt(10);
		t_defaults();
		t_strings();
		t_latch();
		t_doubler();
		t_freq();
		t_strap();
		complete_run();
	end
endmodule : test_bfc_top
`default_nettype wire
